// *** sxn_regs.svh ***
// opcodes, feature addresses, sizes and timing counts of the serial nand sequencer
// assumes a 125 MHz system clock; included by the package users
`ifndef SXN_REGS_SVH
`define SXN_REGS_SVH

`define SXN_OPC_WREN 8'h06
`define SXN_OPC_LOAD 8'h02
`define SXN_OPC_LOAD4 8'h32
`define SXN_OPC_RLOAD 8'h84
`define SXN_OPC_RLOAD4 8'h34
`define SXN_OPC_EXEC 8'h10
`define SXN_OPC_PREAD 8'h13
`define SXN_OPC_ERASE 8'hD8
`define SXN_OPC_GETF 8'h0F
`define SXN_OPC_SETF 8'h1F
`define SXN_OPC_RDC 8'h03

`define SXN_FA_CFG 8'hB0
`define SXN_FA_STAT 8'hC0
`define SXN_CFG_RESET 8'h10
`define SXN_CFG_SPECIAL_BIT 6

`define SXN_CACHE_BYTES 2176
`define SXN_UID_BYTES 16
`define SXN_UID_AREA 12'h200

`define SXN_PP_IOCAP_IDX 8'h80
`define SXN_PP_IOCAP 8'h08
`define SXN_PP_ARRAY_PROGRAM_BUSY_TIME_LO_IDX 8'h85
`define SXN_PP_ARRAY_PROGRAM_BUSY_TIME_LO 8'h58
`define SXN_PP_ARRAY_PROGRAM_BUSY_TIME_HI_IDX 8'h86
`define SXN_PP_ARRAY_PROGRAM_BUSY_TIME_HI 8'h02
`define SXN_PP_BLOCK_ERASE_BUSY_TIME_LO_IDX 8'h87
`define SXN_PP_BLOCK_ERASE_BUSY_TIME_LO 8'h10
`define SXN_PP_BLOCK_ERASE_BUSY_TIME_HI_IDX 8'h88
`define SXN_PP_BLOCK_ERASE_BUSY_TIME_HI 8'h27
`define SXN_PP_TR_LO_IDX 8'h89
`define SXN_PP_TR_LO 8'h46
`define SXN_PP_TR_HI_IDX 8'h8A
`define SXN_PP_TR_HI 8'h00
`define SXN_PP_ECC_IDX 8'hF8
`define SXN_PP_ECC 8'h08

`define SXN_CLK_NS 8
`define SXN_PROG_US 600
`define SXN_ERS_US 10000
`define SXN_READ_US 70
`define SXN_PROG_CYC ((`SXN_PROG_US * 1000) / `SXN_CLK_NS)
`define SXN_ERS_CYC ((`SXN_ERS_US * 1000) / `SXN_CLK_NS)
`define SXN_READ_CYC ((`SXN_READ_US * 1000) / `SXN_CLK_NS)

`endif

// *** sxn_pkg.sv ***
// types shared by the serial nand sequencer and its special page rom
// no constants here; those live in sxn_regs.svh
package sxn_pkg;
   typedef struct packed {
      logic sck;
      logic csN;
      logic [3:0] io;
   } sxn_pins_t;

   typedef struct packed {
      logic crbsy;
      logic [2:0] eccs;
      logic pFail;
      logic eFail;
      logic writeEnableLatch;
      logic operationInProgress;
   } sxn_status_t;

   typedef struct packed {
      logic progReq;
      logic eraseReq;
      logic readReq;
      logic [23:0] rowAddr;
   } sxn_arr_t;

   typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_OUT, ST_SKIP} sxn_frame_t;
endpackage : sxn_pkg

// *** sxn_special_rom.sv ***
// byte source for the unique id page and the parameter page tail
// assumes idx walks the cache; purely combinational
`timescale 1ns/1ps
`include "sxn_regs.svh"
module sxn_special_rom (
   input wire logic [11:0] idx,
   input wire logic paramSel,
   input wire logic [127:0] uidValue,
   output logic [7:0] romByte
);
   import sxn_pkg::*;
   logic [7:0] uidByte;
   logic [7:0] parByte;

   ////////////////////////////////////////////////////////////////////////////
   // sixteen 32-byte copies: id then its complement
   always_comb begin
      uidByte = uidValue[{idx[3:0], 3'b000} +: 8];
      if (idx >= `SXN_UID_AREA)
         uidByte = 8'hFF;
      else if (idx[4])
         uidByte = ~uidByte;
   end

   ////////////////////////////////////////////////////////////////////////////
   // table repeats every 256 bytes; unlisted bytes read zero
   always_comb begin
      case (idx[7:0])
         `SXN_PP_IOCAP_IDX: parByte = `SXN_PP_IOCAP;
         `SXN_PP_ARRAY_PROGRAM_BUSY_TIME_LO_IDX: parByte = `SXN_PP_ARRAY_PROGRAM_BUSY_TIME_LO;
         `SXN_PP_ARRAY_PROGRAM_BUSY_TIME_HI_IDX: parByte = `SXN_PP_ARRAY_PROGRAM_BUSY_TIME_HI;
         `SXN_PP_BLOCK_ERASE_BUSY_TIME_LO_IDX: parByte = `SXN_PP_BLOCK_ERASE_BUSY_TIME_LO;
         `SXN_PP_BLOCK_ERASE_BUSY_TIME_HI_IDX: parByte = `SXN_PP_BLOCK_ERASE_BUSY_TIME_HI;
         `SXN_PP_TR_LO_IDX: parByte = `SXN_PP_TR_LO;
         `SXN_PP_TR_HI_IDX: parByte = `SXN_PP_TR_HI;
         `SXN_PP_ECC_IDX: parByte = `SXN_PP_ECC;
         default: parByte = 8'h00;
      endcase
   end

   assign romByte = paramSel ? parByte : uidByte;
endmodule : sxn_special_rom

// *** sxn_seq.sv ***
// serial nand program, erase and special page command sequencer
// assumes the host drives sck and csN; pins are async to clk_sys
// Summary of operation
// - Read-from-cache at column zero shifts out the unique id bytes.
// - Sixteen 32-byte id copies: sixteen id bytes then their complement.
// - Load accepts up to 2176 bytes; further bytes are discarded.
// - Memory-changing commands need write enable, which sets the latch.
// - Load frame: opcode, three dummies, plane bit, 12-bit column, data.
// - Chip select rising ends a load and stops data intake.
// - Execute takes 24-bit row, moves cache to array, busy meanwhile.
// - Normal load fills cache with FFh first; random load does not.
// - Quad loads 32h and 34h take data on four lines.
// - Block erase D8h erases one 64-page block, status polled after.
// - Without write enable the erase sequence is ignored.
// - Erase takes 24-bit address, then stays busy for erase time.
// - Parameter page holds max program, erase and read times, low first.
// - Parameter page holds correction capability 08h and repeats every 256.
// - Status incl. busy and latch reads at C0h; latch set by enable.
// - Program or erase on a locked block fails and sets fail bit.
`timescale 1ns/1ps
`include "sxn_regs.svh"
module sxn_seq #(
   parameter int CACHE_BYTES = `SXN_CACHE_BYTES,
   parameter int PROG_CYC = `SXN_PROG_CYC,
   parameter int ERS_CYC = `SXN_ERS_CYC,
   parameter int READ_CYC = `SXN_READ_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire sxn_pkg::sxn_pins_t pins,
   input wire logic blockLocked,
   input wire logic [127:0] uidValue,
   output logic soOut,
   output logic soOe,
   output sxn_pkg::sxn_arr_t arrReq,
   output sxn_pkg::sxn_status_t status,
   output logic [7:0] cfgOut
);
   import sxn_pkg::*;
   localparam logic [11:0] CACHE_LIM = 12'(CACHE_BYTES);

   sxn_pins_t pinsMeta_ff, pinsSync_ff;
   logic sckDly_ff;
   sxn_frame_t state_ff, nxtState;
   logic [4:0] cnt_ff, addrLen_ff, nxtLen;
   logic [23:0] sh_ff;
   logic [7:0] opc_ff, fa_ff, rx_ff, tx_ff, cfg_ff;
   logic [11:0] colPtr_ff, colInc, copyIdx_ff;
   logic wel_ff, oip_ff, pFail_ff, eFail_ff, copyAct_ff, copySel_ff, soOut_ff, soOe_ff;
   logic [31:0] timer_ff;
   sxn_arr_t arr_ff;
   logic [7:0] cache_ff [CACHE_BYTES];
   logic [7:0] romByte, cacheByte, opcNow, rxNow;
   logic [23:0] addrNow;
   logic sckRise, sckFall, riseIn, opcDone, addrDone, byteDone, isQuad, isLoad;
   logic welSetP, fillP, wrP, launchP, cfgWrP;
   sxn_status_t statusNow;

   ////////////////////////////////////////////////////////////////////////////
   // two-flop pin sync, then a third stage for sck edges
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinsMeta_ff <= '{sck: 1'b0, csN: 1'b1, io: 4'h0};
         pinsSync_ff <= '{sck: 1'b0, csN: 1'b1, io: 4'h0};
         sckDly_ff <= 1'b0;
      end else begin
         pinsMeta_ff <= pins;
         pinsSync_ff <= pinsMeta_ff;
         sckDly_ff <= pinsSync_ff.sck;
      end
   end

   assign sckRise = pinsSync_ff.sck & ~sckDly_ff;
   assign sckFall = ~pinsSync_ff.sck & sckDly_ff;
   assign riseIn = sckRise & ~pinsSync_ff.csN;
   assign opcNow = {sh_ff[6:0], pinsSync_ff.io[0]};
   assign addrNow = {sh_ff[22:0], pinsSync_ff.io[0]};
   assign isQuad = (opc_ff == `SXN_OPC_LOAD4) || (opc_ff == `SXN_OPC_RLOAD4);
   assign isLoad = isQuad || (opc_ff == `SXN_OPC_LOAD) || (opc_ff == `SXN_OPC_RLOAD);
   assign rxNow = isQuad ? {rx_ff[3:0], pinsSync_ff.io} : {rx_ff[6:0], pinsSync_ff.io[0]};
   assign opcDone = riseIn && (state_ff == ST_OPC) && (cnt_ff == 5'd7);
   assign addrDone = riseIn && (state_ff == ST_ADDR) && (cnt_ff == addrLen_ff - 5'd1);
   assign byteDone = riseIn && (state_ff == ST_DATA) && (isQuad ? cnt_ff[0] : (cnt_ff == 5'd7));
   assign welSetP = opcDone && (opcNow == `SXN_OPC_WREN) && !oip_ff;
   assign fillP = opcDone && wel_ff && !oip_ff
      && ((opcNow == `SXN_OPC_LOAD) || (opcNow == `SXN_OPC_LOAD4));
   assign wrP = byteDone && isLoad && (colPtr_ff < CACHE_LIM);
   assign cfgWrP = byteDone && (opc_ff == `SXN_OPC_SETF) && (fa_ff == `SXN_FA_CFG);
   assign launchP = addrDone && ((opc_ff == `SXN_OPC_EXEC) || (opc_ff == `SXN_OPC_ERASE)
      || (opc_ff == `SXN_OPC_PREAD));
   assign cacheByte = (colPtr_ff < CACHE_LIM) ? cache_ff[colPtr_ff] : 8'hFF;
   assign colInc = (colPtr_ff < CACHE_LIM) ? colPtr_ff + 12'h001 : colPtr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // opcode decode; while busy only get-feature reads are honoured
   always_comb begin
      nxtState = ST_SKIP;
      nxtLen = 5'd24;
      case (opcNow)
         `SXN_OPC_GETF: begin
            nxtState = ST_ADDR;
            nxtLen = 5'd8;
         end
         `SXN_OPC_SETF: begin
            nxtState = oip_ff ? ST_SKIP : ST_ADDR;
            nxtLen = 5'd8;
         end
         `SXN_OPC_LOAD, `SXN_OPC_LOAD4, `SXN_OPC_RLOAD, `SXN_OPC_RLOAD4: begin
            nxtState = (wel_ff && !oip_ff) ? ST_ADDR : ST_SKIP;
            nxtLen = 5'd16;
         end
         `SXN_OPC_EXEC, `SXN_OPC_ERASE: begin
            nxtState = (wel_ff && !oip_ff) ? ST_ADDR : ST_SKIP;
         end
         `SXN_OPC_PREAD: begin
            nxtState = oip_ff ? ST_SKIP : ST_ADDR;
         end
         `SXN_OPC_RDC: begin
            nxtState = oip_ff ? ST_SKIP : ST_ADDR;
            nxtLen = 5'd16;
         end
         default: nxtState = ST_SKIP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer; csN high aborts whatever is in flight
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_OPC;
         cnt_ff <= 5'd0;
         addrLen_ff <= 5'd24;
         sh_ff <= 24'h000000;
         opc_ff <= 8'h00;
         fa_ff <= 8'h00;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         colPtr_ff <= 12'h000;
         soOut_ff <= 1'b0;
         soOe_ff <= 1'b0;
      end else if (pinsSync_ff.csN) begin
         state_ff <= ST_OPC;
         cnt_ff <= 5'd0;
         soOe_ff <= 1'b0;
      end else if (sckRise) begin
         case (state_ff)
            ST_OPC: begin
               sh_ff <= addrNow;
               cnt_ff <= cnt_ff + 5'd1;
               if (opcDone) begin
                  opc_ff <= opcNow;
                  cnt_ff <= 5'd0;
                  state_ff <= nxtState;
                  addrLen_ff <= nxtLen;
               end
            end
            ST_ADDR: begin
               sh_ff <= addrNow;
               cnt_ff <= cnt_ff + 5'd1;
               if (addrDone) begin
                  cnt_ff <= 5'd0;
                  fa_ff <= addrNow[7:0];
                  colPtr_ff <= addrNow[11:0]; // plane and dummies dropped
                  if (opc_ff == `SXN_OPC_GETF) begin
                     state_ff <= ST_OUT;
                     tx_ff <= (addrNow[7:0] == `SXN_FA_STAT) ? statusNow
                        : ((addrNow[7:0] == `SXN_FA_CFG) ? cfg_ff : 8'h00);
                  end else if (opc_ff == `SXN_OPC_RDC)
                     state_ff <= ST_DUMMY;
                  else if (isLoad || (opc_ff == `SXN_OPC_SETF))
                     state_ff <= ST_DATA;
                  else
                     state_ff <= ST_SKIP;
               end
            end
            ST_DUMMY: begin
               cnt_ff <= cnt_ff + 5'd1;
               if (cnt_ff == 5'd7) begin
                  tx_ff <= cacheByte;
                  colPtr_ff <= colInc;
                  cnt_ff <= 5'd0;
                  state_ff <= ST_OUT;
               end
            end
            ST_DATA: begin
               rx_ff <= rxNow;
               cnt_ff <= byteDone ? 5'd0 : cnt_ff + 5'd1;
               if (byteDone) begin
                  colPtr_ff <= colInc; // pointer parks at the end
                  if (opc_ff == `SXN_OPC_SETF)
                     state_ff <= ST_SKIP;
               end
            end
            default: ;
         endcase
      end else if (sckFall && (state_ff == ST_OUT)) begin
         // data changes on falling sck so the host samples it stable
         soOut_ff <= tx_ff[7];
         soOe_ff <= 1'b1;
         tx_ff <= {tx_ff[6:0], 1'b0};
         cnt_ff <= cnt_ff + 5'd1;
         if (cnt_ff == 5'd7) begin
            cnt_ff <= 5'd0;
            if (opc_ff == `SXN_OPC_RDC) begin
               tx_ff <= cacheByte;
               colPtr_ff <= colInc;
            end else
               tx_ff <= statusNow; // repeated status lets one frame poll
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write enable latch: set wins over the clear at launch
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         wel_ff <= 1'b0;
      else if (welSetP)
         wel_ff <= 1'b1;
      else if (launchP && (opc_ff != `SXN_OPC_PREAD))
         wel_ff <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         cfg_ff <= `SXN_CFG_RESET;
      else if (cfgWrP)
         cfg_ff <= rxNow;
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy timer, fail flags and array requests
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         oip_ff <= 1'b0;
         timer_ff <= 32'h0;
         pFail_ff <= 1'b0;
         eFail_ff <= 1'b0;
         arr_ff <= '0;
         copyAct_ff <= 1'b0;
         copySel_ff <= 1'b0;
         copyIdx_ff <= 12'h000;
      end else begin
         arr_ff.progReq <= 1'b0;
         arr_ff.eraseReq <= 1'b0;
         arr_ff.readReq <= 1'b0;
         if (launchP) begin
            arr_ff.rowAddr <= addrNow;
            if (opc_ff == `SXN_OPC_PREAD) begin
               oip_ff <= 1'b1;
               timer_ff <= 32'(READ_CYC - 1);
               arr_ff.readReq <= 1'b1;
               copyAct_ff <= cfg_ff[`SXN_CFG_SPECIAL_BIT] && (addrNow[23:1] == 23'h0);
               copySel_ff <= addrNow[0];
               copyIdx_ff <= 12'h000;
            end else if (blockLocked) begin
               // locked target: flag the failure, no busy, array untouched
               pFail_ff <= pFail_ff || (opc_ff == `SXN_OPC_EXEC);
               eFail_ff <= eFail_ff || (opc_ff == `SXN_OPC_ERASE);
            end else if (opc_ff == `SXN_OPC_EXEC) begin
               pFail_ff <= 1'b0;
               oip_ff <= 1'b1;
               timer_ff <= 32'(PROG_CYC - 1);
               arr_ff.progReq <= 1'b1;
            end else begin
               eFail_ff <= 1'b0;
               oip_ff <= 1'b1;
               timer_ff <= 32'(ERS_CYC - 1);
               arr_ff.eraseReq <= 1'b1;
            end
         end else if (oip_ff) begin
            if (timer_ff != 32'h0)
               timer_ff <= timer_ff - 32'h1;
            if (copyAct_ff) begin
               copyIdx_ff <= copyIdx_ff + 12'h001;
               if (copyIdx_ff == CACHE_LIM - 12'h001)
                  copyAct_ff <= 1'b0;
            end
            if ((timer_ff == 32'h0) && !copyAct_ff)
               oip_ff <= 1'b0;
         end
      end
   end

   sxn_special_rom u_rom (
      .idx(copyIdx_ff),
      .paramSel(copySel_ff),
      .uidValue(uidValue),
      .romByte(romByte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // cache: no reset, it is plain data storage
   always_ff @(posedge clk_sys) begin
      if (fillP) begin
         for (int i = 0; i < CACHE_BYTES; i++)
            cache_ff[i] <= 8'hFF;
      end else if (wrP)
         cache_ff[colPtr_ff] <= rxNow;
      else if (oip_ff && copyAct_ff)
         cache_ff[copyIdx_ff] <= romByte;
   end

   assign statusNow = '{crbsy: 1'b0, eccs: 3'b000, pFail: pFail_ff, eFail: eFail_ff,
      writeEnableLatch: wel_ff, operationInProgress: oip_ff};
   assign status = statusNow;
   assign soOut = soOut_ff;
   assign soOe = soOe_ff;
   assign arrReq = arr_ff;
   assign cfgOut = cfg_ff;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cbSys @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_WEL_SET: assert property (welSetP |=> wel_ff)
      else $error("write enable did not set latch");
   AST_PROG_GATE: assert property ($rose(arr_ff.progReq) |-> $past(wel_ff))
      else $error("program started without write enable");
   AST_ERASE_GATE: assert property ((opcDone && opcNow == `SXN_OPC_ERASE && !wel_ff)
      |=> state_ff == ST_SKIP ##1 !arr_ff.eraseReq)
      else $error("erase not ignored without write enable");
   AST_FILL: assert property (fillP |=> cache_ff[CACHE_BYTES - 1] == 8'hFF)
      else $error("cache not filled on load");
   AST_NO_OVERRUN: assert property ((byteDone && colPtr_ff >= CACHE_LIM)
      |=> $stable(colPtr_ff))
      else $error("load ran past cache end");
   AST_PROG_BUSY: assert property (arr_ff.progReq
      |-> oip_ff && timer_ff == 32'(PROG_CYC - 1))
      else $error("program busy not started");
   AST_ERASE_BUSY: assert property (arr_ff.eraseReq
      |-> oip_ff && timer_ff == 32'(ERS_CYC - 1))
      else $error("erase busy not started");
   AST_LOCK_FAIL: assert property ((launchP && opc_ff == `SXN_OPC_EXEC && blockLocked)
      |=> pFail_ff && !oip_ff && !arr_ff.progReq)
      else $error("locked program did not fail");
   AST_BUSY_END: assert property ($fell(oip_ff) |-> $past(timer_ff) == 32'h0)
      else $error("busy dropped early");
   AST_CS_END: assert property (pinsSync_ff.csN |=> state_ff == ST_OPC && !soOe_ff)
      else $error("frame not ended by chip select");
   AST_UID_COMP: assert property ((oip_ff && copyAct_ff && !copySel_ff && copyIdx_ff[4]
      && copyIdx_ff < `SXN_UID_AREA)
      |-> romByte == ~uidValue[{copyIdx_ff[3:0], 3'b000} +: 8])
      else $error("id complement half wrong");
endmodule : sxn_seq

// *** sxn_host_model.sv ***
// host side of the serial link: drives sck, csN and io, samples soOut
// assumes clk_sys at 125 MHz; sck period of 21 clk_sys cycles (168 ns)
`timescale 1ns/1ps
module sxn_host_model (
   input wire logic clk_sys,
   input wire logic soOut,
   output sxn_pkg::sxn_pins_t pins
);
   import sxn_pkg::*;
   logic [7:0] rxByte;
   ////////////////////////////////////////////////////////////////////////////////
   initial pins = '{sck: 1'b0, csN: 1'b1, io: 4'hA};
   // mode 0: data set while sck low, sampled on rise; x1 data on io[0]
   task automatic xbyte(input logic [7:0] b, input bit quad);
      for (int i = 0; i < (quad ? 2 : 8); i++) begin
         @(negedge clk_sys);
         pins.io <= quad ? (i == 0 ? b[7:4] : b[3:0]) : {3'b101, b[7-i]};
         repeat (10) @(negedge clk_sys);
         pins.sck <= 1'b1;
         rxByte <= {rxByte[6:0], soOut};
         repeat (10) @(negedge clk_sys);
         pins.sck <= 1'b0;
      end
   endtask : xbyte
   ////////////////////////////////////////////////////////////////////////////////
   // one whole command framed by csN; sck stands still between frames
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
                        input logic [7:0] dat[$], input bit quad, input int nrd,
                        output logic [7:0] rd[$]);
      rd = {};
      @(negedge clk_sys);
      pins.csN <= 1'b0;
      xbyte(op, 1'b0);
      for (int i = na - 1; i >= 0; i--) xbyte(a[8*i +: 8], 1'b0);
      foreach (dat[i]) xbyte(dat[i], quad);
      repeat (nrd) begin
         xbyte(8'hFF, 1'b0);
         rd.push_back(rxByte);
      end
      repeat (4) @(negedge clk_sys);
      pins.csN <= 1'b1;
      // released lines must not keep the last value
      pins.io <= ~pins.io;
      repeat (8) @(negedge clk_sys);
   endtask : frame
endmodule : sxn_host_model

// *** sxn_seq_bench.sv ***
// self-checking bench of the serial nand sequencer
// assumes sxn_host_model as the link master; short busy counts
`timescale 1ns/1ps
`include "sxn_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); end end
module sxn_seq_bench;
   import sxn_pkg::*;
   localparam int ERS_CYC = 40;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic blockLocked = 1'b0;
   logic [127:0] uidValue = 128'h0123456789ABCDEF1F2E3D4C5B6A7988;
   sxn_pins_t pins;
   logic soOut;
   logic soOe;
   sxn_arr_t arrReq;
   sxn_status_t status;
   logic [7:0] cfgOut;
   logic [7:0] rd[$];
   logic [7:0] none[$];
   int bad_count = 0;
   int check_count = 0;
   int progSeen = 0;
   int eraseSeen = 0;
   int readSeen = 0;
   int busyLen = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #4 clk_sys = ~clk_sys;
   sxn_seq #(.PROG_CYC(20), .ERS_CYC(ERS_CYC), .READ_CYC(3000)) dut (.clk_sys(clk_sys),
      .rst_b(rst_b), .pins(pins), .blockLocked(blockLocked), .uidValue(uidValue),
      .soOut(soOut), .soOe(soOe), .arrReq(arrReq), .status(status), .cfgOut(cfgOut));
   sxn_host_model host (.clk_sys(clk_sys), .soOut(soOut), .pins(pins));
   always @(posedge clk_sys) begin
      if (arrReq.progReq) progSeen <= progSeen + 1;
      if (arrReq.eraseReq) eraseSeen <= eraseSeen + 1;
      if (arrReq.readReq) readSeen <= readSeen + 1;
      if (status.operationInProgress) busyLen <= busyLen + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic f(input logic [7:0] op, input logic [23:0] a, input int na,
                    input logic [7:0] dat[$], input bit quad, input int nrd);
      host.frame(op, a, na, dat, quad, nrd, rd);
   endtask : f
   // status poll, bounded
   task automatic wait_idle;
      int n = 0;
      do begin
         f(`SXN_OPC_GETF, `SXN_FA_STAT, 1, none, 0, 1);
         n++;
      end while (rd[0][0] !== 1'b0 && n < 20);
      if (rd[0][0] !== 1'b0) begin
         bad_count++;
         print_verdict();
      end
   endtask : wait_idle
   task automatic rdc(input logic [11:0] col, input int n);
      f(`SXN_OPC_RDC, {4'h0, col, 8'h00}, 3, none, 0, n);
   endtask : rdc
   task automatic wren;
      f(`SXN_OPC_WREN, 24'h0, 0, none, 0, 0);
   endtask : wren
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_erase;
      f(`SXN_OPC_ERASE, 24'h000080, 3, none, 0, 0);
      `CHK(eraseSeen, 0)
      `CHK(status, 8'h00)
      wren();
      f(`SXN_OPC_GETF, `SXN_FA_STAT, 1, none, 0, 1);
      `CHK(rd[0], 8'h02)
      busyLen = 0;
      f(`SXN_OPC_ERASE, 24'h000080, 3, none, 0, 0);
      `CHK(eraseSeen, 1)
      `CHK(arrReq.rowAddr, 24'h000080)
      `CHK(status, 8'h01)
      wait_idle();
      `CHK(busyLen inside {[ERS_CYC:ERS_CYC + 2]}, 1'b1)
   endtask : t_erase
   task automatic t_load;
      wren();
      f(`SXN_OPC_LOAD, 24'h005, 2, {8'hA5}, 0, 0);
      rdc(12'h004, 2);
      `CHK({rd[0], rd[1]}, 16'hFFA5)
      f(`SXN_OPC_RLOAD, 24'h004, 2, {8'h3C}, 0, 0);
      rdc(12'h004, 2);
      `CHK({rd[0], rd[1]}, 16'h3CA5)
      f(`SXN_OPC_LOAD4, 24'h008, 2, {8'h5A, 8'hC3}, 1, 0);
      rdc(12'h005, 5);
      `CHK({rd[0], rd[3], rd[4]}, 24'hFF5AC3)
      f(`SXN_OPC_RLOAD, 24'h87F, 2, {8'h11, 8'h22}, 0, 0);
      f(`SXN_OPC_RLOAD4, 24'h001, 2, {8'h77}, 1, 0);
      rdc(12'h87F, 1);
      `CHK(rd[0], 8'h11)
      rdc(12'h000, 2);
      `CHK({rd[0], rd[1]}, 16'hFF77)
      `CHK(status.writeEnableLatch, 1'b1)
      f(`SXN_OPC_EXEC, 24'h000123, 3, none, 0, 0);
      `CHK(progSeen, 1)
      `CHK(arrReq.rowAddr, 24'h000123)
      `CHK(status, 8'h01)
      wait_idle();
   endtask : t_load
   task automatic t_locked;
      blockLocked = 1'b1;
      wren();
      f(`SXN_OPC_EXEC, 24'h000040, 3, none, 0, 0);
      wren();
      f(`SXN_OPC_ERASE, 24'h000040, 3, none, 0, 0);
      f(`SXN_OPC_GETF, `SXN_FA_STAT, 1, none, 0, 1);
      `CHK(rd[0], 8'h0C)
      `CHK(progSeen + eraseSeen, 2)
      blockLocked = 1'b0;
   endtask : t_locked
   task automatic t_special;
      f(`SXN_OPC_SETF, `SXN_FA_CFG, 1, {8'h40}, 0, 0);
      `CHK(cfgOut, 8'h40)
      f(`SXN_OPC_PREAD, 24'h0, 3, none, 0, 0);
      wait_idle();
      rdc(12'h000, 32);
      for (int k = 0; k < 16; k++) begin
         `CHK(rd[k], uidValue[8*k +: 8])
         `CHK(rd[k] ^ rd[k+16], 8'hFF)
      end
      f(`SXN_OPC_PREAD, 24'h1, 3, none, 0, 0);
      wait_idle();
      rdc(12'd133, 6);
      `CHK({rd[0], rd[1], rd[2], rd[3], rd[4], rd[5]}, 48'h58021027_4600)
      rdc(12'd248, 1);
      `CHK(rd[0], 8'h08)
      rdc(12'd504, 1);
      `CHK(rd[0], 8'h08)
      f(`SXN_OPC_SETF, `SXN_FA_CFG, 1, {8'h10}, 0, 0);
      `CHK(cfgOut, 8'h10)
   endtask : t_special
   // data move on the cache left by the parameter page copy
   task automatic t_move;
      f(`SXN_OPC_PREAD, 24'h000200, 3, none, 0, 0);
      `CHK(readSeen, 3)
      `CHK(arrReq.rowAddr, 24'h000200)
      wait_idle();
      wren();
      f(`SXN_OPC_RLOAD, 24'h081, 2, {8'h99}, 0, 0);
      f(`SXN_OPC_EXEC, 24'h000200, 3, none, 0, 0);
      `CHK(progSeen, 2)
      wait_idle();
      `CHK(rd[0], 8'h04)
      rdc(12'h080, 2);
      `CHK({rd[0], rd[1]}, {`SXN_PP_IOCAP, 8'h99})
   endtask : t_move
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #560000;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst_b = 1'b1;
      `CHK({status, cfgOut, soOe, arrReq}, {16'h0010, 1'b0, 27'h0})
      repeat (4) @(negedge clk_sys);
      t_erase();
      t_load();
      t_locked();
      t_special();
      t_move();
      print_verdict();
   end
endmodule : sxn_seq_bench
